// ==== hdl/dbc_pkg.sv ====
// Constants, command and state types for the bank busy-state command checker.
package dbc_pkg;

  // Device organisation, pin widths and counter width.
  localparam int NUM_BANKS     = 4;
  localparam int BANK_W        = 2;
  localparam int CNT_W         = 8;

  // Clock and timing figures, each in its own unit.
  localparam int CLK_PERIOD_NS        = 40;
  localparam int CLOSE_TIME_NS        = 15;
  localparam int OPEN_TO_COL_NS       = 15;
  localparam int WRITE_RECOVERY_NS    = 15;
  localparam int REFRESH_CYCLE_NS     = 105;
  localparam int MODE_SET_DELAY_CLK   = 2;
  localparam int BURST4_CLK           = 2;
  localparam int BURST8_CLK           = 4;

  // Least times round up to whole cycles and never drop below one.
  localparam int CLOSE_CLK   = ((CLOSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (CLOSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_CLK    = ((OPEN_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (OPEN_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WREC_CLK    = ((WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CLK = ((REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter load values: a timer loaded with N-1 expires N edges later.
  localparam logic [CNT_W-1:0] CLOSE_LD   = CNT_W'(CLOSE_CLK - 1);
  localparam logic [CNT_W-1:0] OPEN_LD    = CNT_W'(OPEN_CLK - 1);
  localparam logic [CNT_W-1:0] WREC_LD    = CNT_W'(WREC_CLK - 1);
  localparam logic [CNT_W-1:0] REFRESH_LD = CNT_W'(REFRESH_CLK - 1);
  localparam logic [CNT_W-1:0] MODE_LD    = CNT_W'(MODE_SET_DELAY_CLK - 1);
  localparam logic [CNT_W-1:0] BURST4_LD  = CNT_W'(BURST4_CLK - 1);
  localparam logic [CNT_W-1:0] BURST8_LD  = CNT_W'(BURST8_CLK - 1);
  // Remaining count seen at the edge that sits on a 4-beat boundary of an 8-beat burst.
  localparam logic [CNT_W-1:0] BURST_HALF = CNT_W'(BURST8_CLK / 2);

  typedef enum logic [2:0] {
    DBC_C_DESEL, DBC_C_NOP, DBC_C_READ, DBC_C_WRITE,
    DBC_C_OPEN, DBC_C_CLOSE, DBC_C_REFRESH, DBC_C_MODE
  } dbc_cmd_e;

  typedef enum logic [3:0] {
    DBC_B_IDLE, DBC_B_ACTIVE, DBC_B_OPENING, DBC_B_CLOSING,
    DBC_B_READING, DBC_B_READ_AC, DBC_B_WRITING, DBC_B_WRITE_AC,
    DBC_B_WREC, DBC_B_WREC_AC
  } dbc_bank_e;

  typedef enum logic [1:0] {
    DBC_G_IDLE, DBC_G_REFRESH, DBC_G_MODE
  } dbc_glob_e;

  typedef struct packed {
    dbc_bank_e [NUM_BANKS-1:0]             bank_st;
    logic      [NUM_BANKS-1:0][CNT_W-1:0] bank_cnt;
    dbc_glob_e                             glob_st;
    logic      [CNT_W-1:0]                 glob_cnt;
    logic                                  illegal;
  } dbc_state_s;

endpackage : dbc_pkg

// ==== hdl/dbc_bank_check.sv ====
// Per-bank command decoder, busy-state tracker and legality checker.
`timescale 1ns/100ps

// How it works
// - Command comes from chip select and three strobes; chip select high is deselect.
// - Command sampled each edge is judged against bank state held before it.
// - Deselect or no-operation lets an auto-close burst run to its last beat.
// - Closing bank goes idle after close time; further close acts as no-operation.
// - Opening bank goes active after open-to-column delay; any command to it but no-op before is illegal.
// - Write recovery returns to active after recovery time; new write allowed meanwhile.
// - Write recovery with auto-close starts closing after recovery; only no-op allowed.
// - After auto refresh device idles after refresh cycle time; only no-op meanwhile.
// - After mode set device idles after mode-set delay; only no-op meanwhile.
module dbc_bank_check
  import dbc_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Command pins
  input  wire logic                      cs_n,
  input  wire logic                      ras_n,
  input  wire logic                      cas_n,
  input  wire logic                      we_n,
  input  wire logic [BANK_W-1:0]         bank,
  input  wire logic                      auto_close_flag,
  // Burst length setting, high for 8 beats
  input  wire logic                      burst_len8,
  // Status
  output logic      [NUM_BANKS*4-1:0]    bank_state,
  output logic                           cmd_illegal,
  output logic                           all_idle,
  output logic                           dev_busy
);

  dbc_state_s st;
  dbc_state_s next_st;
  dbc_cmd_e   cmd;
  logic       banks_idle;
  logic       close_all_ok;
  logic [CNT_W-1:0] burst_ld;

  // Strobe patterns map onto commands; 3'b000 and 3'b110 both decode as mode set.
  always_comb begin
    if (cs_n) begin
      cmd = DBC_C_DESEL;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'b111:  cmd = DBC_C_NOP;
        3'b101:  cmd = DBC_C_READ;
        3'b100:  cmd = DBC_C_WRITE;
        3'b011:  cmd = DBC_C_OPEN;
        3'b010:  cmd = DBC_C_CLOSE;
        3'b001:  cmd = DBC_C_REFRESH;
        default: cmd = DBC_C_MODE;
      endcase
    end
  end

  assign burst_ld = burst_len8 ? BURST8_LD : BURST4_LD;

  always_comb begin
    banks_idle   = 1'b1;
    close_all_ok = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (st.bank_st[b] != DBC_B_IDLE) begin
        banks_idle = 1'b0;
      end
      if (!(st.bank_st[b] inside {DBC_B_IDLE, DBC_B_ACTIVE, DBC_B_CLOSING})) begin
        close_all_ok = 1'b0;
      end
    end
  end

  always_comb begin
    next_st         = st;
    next_st.illegal = 1'b0;
    // Device-wide timers for refresh and mode access.
    if (st.glob_st != DBC_G_IDLE) begin
      if (st.glob_cnt != '0) begin
        next_st.glob_cnt = st.glob_cnt - 1'b1;
      end else begin
        next_st.glob_st = DBC_G_IDLE;
      end
    end
    // Timed progress of each bank, overridden below by a legal command.
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (st.bank_cnt[b] != '0) begin
        next_st.bank_cnt[b] = st.bank_cnt[b] - 1'b1;
      end else begin
        unique case (st.bank_st[b])
          DBC_B_OPENING: next_st.bank_st[b] = DBC_B_ACTIVE;
          DBC_B_CLOSING: next_st.bank_st[b] = DBC_B_IDLE;
          DBC_B_READING: next_st.bank_st[b] = DBC_B_ACTIVE;
          DBC_B_READ_AC: begin
            next_st.bank_st[b]  = DBC_B_CLOSING;
            next_st.bank_cnt[b] = CLOSE_LD;
          end
          DBC_B_WRITING: begin
            next_st.bank_st[b]  = DBC_B_WREC;
            next_st.bank_cnt[b] = WREC_LD;
          end
          DBC_B_WRITE_AC: begin
            next_st.bank_st[b]  = DBC_B_WREC_AC;
            next_st.bank_cnt[b] = WREC_LD;
          end
          DBC_B_WREC:    next_st.bank_st[b] = DBC_B_ACTIVE;
          DBC_B_WREC_AC: begin
            next_st.bank_st[b]  = DBC_B_CLOSING;
            next_st.bank_cnt[b] = CLOSE_LD;
          end
          default: ;
        endcase
      end
    end
    // An illegal command is flagged and otherwise ignored; timers still run.
    unique case (cmd)
      DBC_C_DESEL, DBC_C_NOP: ;
      DBC_C_OPEN: begin
        if (st.glob_st == DBC_G_IDLE && st.bank_st[bank] == DBC_B_IDLE) begin
          next_st.bank_st[bank]  = DBC_B_OPENING;
          next_st.bank_cnt[bank] = OPEN_LD;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
      DBC_C_READ: begin
        if (st.glob_st == DBC_G_IDLE && (st.bank_st[bank] == DBC_B_ACTIVE ||
            (st.bank_st[bank] == DBC_B_READING && burst_len8 &&
             st.bank_cnt[bank] == BURST_HALF))) begin
          next_st.bank_st[bank]  = auto_close_flag ? DBC_B_READ_AC : DBC_B_READING;
          next_st.bank_cnt[bank] = burst_ld;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
      DBC_C_WRITE: begin
        if (st.glob_st == DBC_G_IDLE && (st.bank_st[bank] == DBC_B_ACTIVE ||
            st.bank_st[bank] == DBC_B_WREC ||
            (st.bank_st[bank] == DBC_B_WRITING && burst_len8 &&
             st.bank_cnt[bank] == BURST_HALF))) begin
          next_st.bank_st[bank]  = auto_close_flag ? DBC_B_WRITE_AC : DBC_B_WRITING;
          next_st.bank_cnt[bank] = burst_ld;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
      DBC_C_CLOSE: begin
        if (st.glob_st != DBC_G_IDLE) begin
          next_st.illegal = 1'b1;
        end else if (auto_close_flag) begin
          if (close_all_ok) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
              if (st.bank_st[b] == DBC_B_ACTIVE) begin
                next_st.bank_st[b]  = DBC_B_CLOSING;
                next_st.bank_cnt[b] = CLOSE_LD;
              end
            end
          end else begin
            next_st.illegal = 1'b1;
          end
        end else if (st.bank_st[bank] == DBC_B_ACTIVE) begin
          next_st.bank_st[bank]  = DBC_B_CLOSING;
          next_st.bank_cnt[bank] = CLOSE_LD;
        end else if (!(st.bank_st[bank] inside {DBC_B_IDLE, DBC_B_CLOSING})) begin
          next_st.illegal = 1'b1;
        end
      end
      DBC_C_REFRESH: begin
        if (st.glob_st == DBC_G_IDLE && banks_idle) begin
          next_st.glob_st  = DBC_G_REFRESH;
          next_st.glob_cnt = REFRESH_LD;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
      DBC_C_MODE: begin
        if (st.glob_st == DBC_G_IDLE && banks_idle) begin
          next_st.glob_st  = DBC_G_MODE;
          next_st.glob_cnt = MODE_LD;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
    endcase
  end

  // The whole state advances on one edge, so every judgement uses the pre-edge view.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{bank_st: '{default: DBC_B_IDLE}, bank_cnt: '0, glob_st: DBC_G_IDLE,
              glob_cnt: '0, illegal: 1'b0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign bank_state  = st.bank_st;
  assign cmd_illegal = st.illegal;
  assign all_idle    = banks_idle && (st.glob_st == DBC_G_IDLE);
  assign dev_busy    = (st.glob_st != DBC_G_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence seq_quiet;
    cs_n || cmd == DBC_C_NOP;
  endsequence

  sequence seq_open_done;
    st.bank_st[0] == DBC_B_OPENING && st.bank_cnt[0] == '0;
  endsequence

  chk_desel_legal: assert property (cs_n |=> !cmd_illegal)
    else $error("deselect flagged illegal");
  chk_burst_continues: assert property (
    (st.bank_st[0] == DBC_B_READ_AC && st.bank_cnt[0] != '0) ##0 seq_quiet
    |=> st.bank_st[0] == DBC_B_READ_AC)
    else $error("auto-close read burst cut short");
  chk_close_idle: assert property (
    st.bank_st[0] == DBC_B_CLOSING && st.bank_cnt[0] == '0 |=> st.bank_st[0] == DBC_B_IDLE)
    else $error("closing bank did not go idle");
  chk_open_active: assert property (seq_open_done |=> st.bank_st[0] == DBC_B_ACTIVE)
    else $error("opening bank did not become active");
  chk_open_early: assert property (
    st.bank_st[0] == DBC_B_OPENING && !cs_n && bank == '0 && cmd != DBC_C_NOP
    |=> cmd_illegal)
    else $error("command to opening bank not flagged");
  chk_rec_return: assert property (
    st.bank_st[0] == DBC_B_WREC && st.bank_cnt[0] == '0 && !(cmd == DBC_C_WRITE &&
    bank == '0) |=> st.bank_st[0] == DBC_B_ACTIVE)
    else $error("write recovery did not return to active");
  chk_recac_close: assert property (
    st.bank_st[0] == DBC_B_WREC_AC && st.bank_cnt[0] == '0
    |=> st.bank_st[0] == DBC_B_CLOSING && st.bank_cnt[0] == CLOSE_LD)
    else $error("auto-close recovery did not start closing");
  chk_refresh_busy: assert property (
    st.glob_st == DBC_G_REFRESH && !cs_n && cmd != DBC_C_NOP |=> cmd_illegal)
    else $error("command during refresh not flagged");
  chk_refresh_idle: assert property (
    st.glob_st == DBC_G_REFRESH && st.glob_cnt == '0 |=> st.glob_st == DBC_G_IDLE)
    else $error("refresh did not end on time");
  chk_mode_idle: assert property (
    cmd == DBC_C_MODE && all_idle |=> st.glob_st == DBC_G_MODE ##1
    st.glob_st == DBC_G_MODE ##1 st.glob_st == DBC_G_IDLE)
    else $error("mode access interval wrong");

endmodule : dbc_bank_check

// ==== test/dbc_ctrl_model.sv ====
// Memory controller model that turns a command request into pin levels.
`timescale 1ns/100ps
module dbc_ctrl_model
  import dbc_pkg::*;
(
  // Command request
  input  wire dbc_cmd_e   op,
  input  wire logic [2:0] noise,
  // Command pins
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n
);
  // While deselected the strobes carry changing noise, so a decoder that ignores
  // chip select cannot pass by luck.
  always_comb begin
    {ras_n, cas_n, we_n} = noise;
    cs_n = 1'b0;
    case (op)
      DBC_C_DESEL:   cs_n = 1'b1;
      DBC_C_NOP:     {ras_n, cas_n, we_n} = 3'h7;
      DBC_C_READ:    {ras_n, cas_n, we_n} = 3'h5;
      DBC_C_WRITE:   {ras_n, cas_n, we_n} = 3'h4;
      DBC_C_OPEN:    {ras_n, cas_n, we_n} = 3'h3;
      DBC_C_CLOSE:   {ras_n, cas_n, we_n} = 3'h2;
      DBC_C_REFRESH: {ras_n, cas_n, we_n} = 3'h1;
      default:       {ras_n, cas_n, we_n} = 3'h0;
    endcase
  end
endmodule : dbc_ctrl_model

// ==== test/tb.sv ====
// Self-checking bench for the bank busy-state command checker.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb
  import dbc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        flag = 1'b0;
  logic        bl8 = 1'b0;
  logic [1:0]  bk = 2'h0;
  logic [2:0]  noise = 3'h0;
  logic [7:0]  lf = 8'h52;
  dbc_cmd_e    op = DBC_C_NOP;
  logic        cs_n, ras_n, cas_n, we_n, ill, aid, busy;
  logic [15:0] bst;
  logic        opn [4];
  int          fail_count = 0;
  int          compares = 0;
  int          cyc = 0;

  dbc_ctrl_model i_ctrl (.op(op), .noise(noise), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n));
  dbc_bank_check i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank(bk), .auto_close_flag(flag), .burst_len8(bl8),
    .bank_state(bst), .cmd_illegal(ill), .all_idle(aid), .dev_busy(busy));

  initial begin
    forever #20 clk = ~clk;
  end

  // The directed and random parts need well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt

  function automatic logic exp_ill(input dbc_cmd_e c, input logic [1:0] b);
    return (c == DBC_C_OPEN) && opn[b];
  endfunction : exp_ill

  // Entered and left 2 ns after an edge; the command is taken at the next edge.
  task automatic go(input dbc_cmd_e c, input logic [1:0] b, input logic f, input logic ex);
    op = c;
    bk = b;
    flag = f;
    @(posedge clk);
    #1;
    `CHK("cmd_illegal", ex, ill)
    #1;
  endtask : go

  task automatic idle(input int n);
    op = DBC_C_NOP;
    repeat (n) @(posedge clk);
    #2;
  endtask : idle

  initial begin
    logic [1:0] b;
    dbc_cmd_e   c;
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    `CHK("all_idle", 1'b1, aid)
    `CHK("bank_state", 16'h0, bst)
    go(DBC_C_OPEN, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_OPENING, bst[3:0])
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    `CHK("bank0", DBC_B_ACTIVE, bst[3:0])
    go(DBC_C_READ, 2'h0, 1'b1, 1'b0);
    go(DBC_C_WRITE, 2'h0, 1'b0, 1'b1);
    `CHK("bank0", DBC_B_READ_AC, bst[3:0])
    go(DBC_C_DESEL, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_CLOSING, bst[3:0])
    go(DBC_C_CLOSE, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_IDLE, bst[3:0])
    go(DBC_C_OPEN, 2'h0, 1'b0, 1'b0);
    idle(1);
    go(DBC_C_WRITE, 2'h0, 1'b1, 1'b0);
    go(DBC_C_NOP, 2'h0, 1'b0, 1'b0);
    go(DBC_C_CLOSE, 2'h0, 1'b0, 1'b1);
    `CHK("bank0", DBC_B_WREC_AC, bst[3:0])
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    `CHK("bank0", DBC_B_CLOSING, bst[3:0])
    idle(1);
    go(DBC_C_OPEN, 2'h0, 1'b0, 1'b0);
    idle(1);
    go(DBC_C_WRITE, 2'h0, 1'b0, 1'b0);
    go(DBC_C_OPEN, 2'h1, 1'b0, 1'b0);
    go(DBC_C_NOP, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_WREC, bst[3:0])
    go(DBC_C_WRITE, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_WRITING, bst[3:0])
    idle(2);
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    `CHK("bank0", DBC_B_ACTIVE, bst[3:0])
    `CHK("bank1", DBC_B_ACTIVE, bst[7:4])
    `CHK("all_idle", 1'b0, aid)
    bl8 = 1'b1;
    go(DBC_C_READ, 2'h0, 1'b0, 1'b0);
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    go(DBC_C_READ, 2'h0, 1'b0, 1'b0);
    go(DBC_C_NOP, 2'h0, 1'b0, 1'b0);
    go(DBC_C_WRITE, 2'h0, 1'b0, 1'b1);
    idle(3);
    `CHK("bank0", DBC_B_ACTIVE, bst[3:0])
    bl8 = 1'b0;
    go(DBC_C_READ, 2'h0, 1'b0, 1'b0);
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    idle(2);
    go(DBC_C_REFRESH, 2'h0, 1'b0, 1'b1);
    go(DBC_C_CLOSE, 2'h0, 1'b1, 1'b0);
    idle(1);
    `CHK("all_idle", 1'b1, aid)
    go(DBC_C_REFRESH, 2'h0, 1'b0, 1'b0);
    go(DBC_C_OPEN, 2'h2, 1'b0, 1'b1);
    idle(1);
    `CHK("dev_busy", 1'b1, busy)
    idle(1);
    `CHK("dev_busy", 1'b0, busy)
    go(DBC_C_MODE, 2'h0, 1'b0, 1'b0);
    go(DBC_C_READ, 2'h0, 1'b0, 1'b1);
    `CHK("dev_busy", 1'b1, busy)
    // A low clock enable must freeze the timers and the illegal flag alike.
    ce = 1'b0;
    idle(2);
    `CHK("cmd_illegal", 1'b1, ill)
    `CHK("dev_busy", 1'b1, busy)
    ce = 1'b1;
    idle(1);
    `CHK("dev_busy", 1'b0, busy)
    `CHK("cmd_illegal", 1'b0, ill)
    go(DBC_C_OPEN, 2'h0, 1'b0, 1'b0);
    idle(1);
    go(DBC_C_READ, 2'h0, 1'b1, 1'b0);
    go(DBC_C_NOP, 2'h0, 1'b0, 1'b0);
    `CHK("bank0", DBC_B_READ_AC, bst[3:0])
    idle(2);
    `CHK("bank0", DBC_B_IDLE, bst[3:0])
    foreach (opn[i]) opn[i] = 1'b0;
    for (int i = 0; i < 80; i++) begin
      lf = nxt(lf);
      noise = lf[2:0];
      b = lf[4:3];
      c = (lf[6:5] == 2'h1) ? DBC_C_OPEN : (lf[6:5] == 2'h2) ? DBC_C_CLOSE : DBC_C_DESEL;
      go(c, b, lf[7], exp_ill(c, b));
      if (c == DBC_C_OPEN) opn[b] = 1'b1;
      if (c == DBC_C_CLOSE && lf[7]) foreach (opn[j]) opn[j] = 1'b0;
      else if (c == DBC_C_CLOSE) opn[b] = 1'b0;
      idle(1);
      `CHK("bank", opn[b] ? DBC_B_ACTIVE : DBC_B_IDLE, bst[4*b +: 4])
    end
    results();
  end
endmodule : tb
